// ===== hdl/spfc_pkg.sv
// holds the constants and helpers of the serial target with crc-8 checking
// assumes 16-bit command words sent msb first and data lanes of 8 bits
`default_nettype none
package spfc_pkg;
  // ----------------------------------------------------------------
  // command word layout
  // ----------------------------------------------------------------
  localparam int unsigned SEL_POS = 15;  // device select bit
  localparam int unsigned RW_POS = 14;   // read/write select bit
  localparam int unsigned IDX_MSB = 13;  // register index bits
  localparam int unsigned IDX_LSB = 1;
  localparam int unsigned CMDF_MSB = 13; // index bits that are zero
  localparam int unsigned CMDF_LSB = 6;  // for instruction commands
  localparam logic RW_READ = 1'b1;
  // ----------------------------------------------------------------
  // frame points, counted in falling serial clock edges taken
  // ----------------------------------------------------------------
  localparam logic [6:0] CNT_MAX = 7'h7f;
  localparam logic [6:0] CMD_END = 7'h0f;   // last bit of command word
  localparam logic [6:0] HCRC_END = 7'h17;  // last bit of host crc
  localparam logic [6:0] CMD4_END = 7'h1f;  // last bit of fourth byte
  localparam logic [6:0] RD_NOCRC = 7'h10;  // read data slot, crc off
  localparam logic [6:0] CCRC_OUT = 7'h18;  // device command crc slot
  localparam logic [6:0] RD_CRC = 7'h20;    // read data slot, crc on
  localparam logic [6:0] RET16 = 7'h30;     // payload crc slot, 16 bit
  localparam logic [6:0] RET24 = 7'h38;     // payload crc slot, 24 bit
  // ----------------------------------------------------------------
  // crc and registers
  // ----------------------------------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h07;  // x^8 + x^2 + x + 1
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [12:0] CFG_IDX = 13'h0030;
  localparam logic [12:0] STAT_IDX = 13'h0031;
  localparam logic [23:0] CFG_RST = 24'h000000;
  localparam logic [23:0] STAT_ERR_MASK = 24'h000001;
  localparam int unsigned CFG_CRC_EN = 7;
  localparam int unsigned CFG_STAT_EN = 9;
  localparam int unsigned CFG_ROUTE = 10;
  localparam logic [2:0] LANE_TOP = 3'b100;  // lane of bits 23:16
  localparam logic [3:0] RDY_CYCLES = 4'h2;  // ready pulse length

  // crc-8 over the top n bits of d, msb first, no final inversion
  function automatic logic [7:0] spfc_crc8(input logic [31:0] d,
                                           input logic [5:0] n);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    fb = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (6'(i) < n) begin
        fb = c[7] ^ d[31-i];
        c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
    end
    return c;
  endfunction

  // instruction commands have the upper index bits all zero
  function automatic logic spfc_is_cmd(input logic [15:0] w);
    return w[CMDF_MSB:CMDF_LSB] == 8'h00;
  endfunction
endpackage
`default_nettype wire

// ===== hdl/spfc_spi_crc8.sv
// holds the serial target: frame decode, byte writes, read return and crc-8
// assumes sclk from the host, chip select as frame, clk for the user side
`default_nettype none
// Overview of operation
// - select bit zero means register write
// - commit each byte msb first per eight
// - select bit one returns data on output
// - config bit seven enables crc, off
// - generator polynomial x8 x2 x 1
// - crc is remainder over payload bytes
// - crc follows command word and data
// - command runs only on crc match
// - route bit drives fault onto pin two
// - status fault bit clears when read
// - eight more clocks return payload crc
// - address word ends with zero bit
// - read data followed by device crc
// - non-return command runs at byte four
// - chip select high abandons command
// - status byte included in result crc
// - device crc of command after host crc (sent for reads and non-return commands only, not for register writes)
// - plain result crc over three bytes
// - select bit must match address pin
// - sample falling edge, drive rising edge
// - chip select high resets and floats
// - ready rises once result is buffered
module spfc_spi_crc8
  import spfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic chip_select_low_n,
  input wire logic mosi,
  input wire logic device_select_pin,
  output logic miso,
  output logic miso_oe,
  input wire logic reg_wide,
  input wire logic [23:0] reg_rd_data,
  input wire logic result_load,
  input wire logic [23:0] result_data,
  input wire logic [7:0] result_status,
  output logic result_ready_pulse,
  output logic reg_wr_pulse,
  output logic [12:0] reg_wr_index,
  output logic [2:0] reg_wr_mask,
  output logic [23:0] reg_wr_data,
  output logic cmd_pulse,
  output logic [15:0] cmd_word,
  output logic [23:0] system_config_first,
  output logic [23:0] system_status_first,
  output logic checksum_fault,
  output logic general_pin_two,
  output logic general_pin_two_oe
);
  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_CMD, PH_HCRC, PH_WAIT, PH_WDATA, PH_PCRC, PH_READ, PH_RET, PH_DROP
  } spfc_phase_t;

  // frame state, cleared whenever chip select is high
  typedef struct packed {
    logic [1:0] sel_s;   // address pin sync
    logic [1:0] crc_s;   // crc enable sync
    logic [1:0] stat_s;  // status prefix sync
    logic [1:0] wide_s;  // register width sync
    logic [6:0] cnt;     // falling edges in frame
    logic [31:0] sh;     // received bits
    logic [15:0] cmd;    // command word
    logic [7:0] ccrc;    // crc of command word
    logic [7:0] pcrc;    // crc of write payload
    logic [1:0] nby;     // data bytes taken
    spfc_phase_t ph;     // frame phase
  } spfc_frm_t;

  // events toward the user side, kept across frames
  typedef struct packed {
    logic wr_tog;        // toggles per write
    logic [12:0] wr_idx; // written index
    logic [2:0] wr_mask; // written lanes
    logic [23:0] wr_data;
    logic cmd_tog;       // toggles per command
    logic [15:0] cmd_word;
    logic err_tog;       // toggles per crc fault
  } spfc_evt_t;

  // serial output state, moved on rising edges
  typedef struct packed {
    logic miso;          // bit on the pin
    logic [38:0] tx;     // bits still to send
  } spfc_tx_t;

  // user side state
  typedef struct packed {
    logic lrst;          // reset of link events
    logic [2:0] wr_s;    // write toggle sync
    logic [2:0] cmd_s;   // command toggle sync
    logic [2:0] err_s;   // fault toggle sync
    logic [1:0] act_s;   // frame active sync
    logic [23:0] cfg;    // first config register
    logic crc_err;       // sticky crc fault
    logic wr_p;
    logic [12:0] wr_idx;
    logic [2:0] wr_mask;
    logic [23:0] wr_data;
    logic cmd_p;
    logic [15:0] cmd_word;
    logic [31:0] res;    // status byte and result
    logic [23:0] rdh;    // register read hold
    logic [3:0] rdy_cnt; // ready pulse timer
    logic rdy;
  } spfc_sys_t;

  spfc_frm_t f_q, f_d;
  spfc_evt_t e_q, e_d;
  spfc_tx_t t_q, t_d;
  spfc_sys_t s_q, s_d;

  // ----------------------------------------------------------------
  // link side: receive path on falling edges
  // ----------------------------------------------------------------
  // decode the frame bit by bit and raise events
  always_comb begin
    logic [15:0] w16;
    logic [7:0] by;
    logic [7:0] pc;
    logic [1:0] lane;
    logic wide;
    f_d = f_q;
    e_d = e_q;
    w16 = {f_q.sh[14:0], mosi};
    by = {f_q.sh[6:0], mosi};
    pc = 8'h00;
    wide = f_q.wide_s[1];
    lane = wide ? f_q.nby : f_q.nby + 2'd1;
    f_d.sel_s = {f_q.sel_s[0], device_select_pin};
    f_d.crc_s = {f_q.crc_s[0], s_q.cfg[CFG_CRC_EN]};
    f_d.stat_s = {f_q.stat_s[0], s_q.cfg[CFG_STAT_EN]};
    f_d.wide_s = {f_q.wide_s[0], reg_wide};
    f_d.sh = {f_q.sh[30:0], mosi};
    if (f_q.cnt != CNT_MAX) begin
      f_d.cnt = f_q.cnt + 7'd1;
    end
    unique case (f_q.ph)
      // command word, then pick the path
      PH_CMD: begin
        if (f_q.cnt == CMD_END) begin
          f_d.cmd = w16;
          f_d.ccrc = spfc_crc8({w16, 16'h0000}, 6'd16);
          if (w16[SEL_POS] != f_q.sel_s[1]) begin
            f_d.ph = PH_DROP;
          end else if (f_q.crc_s[1]) begin
            f_d.ph = PH_HCRC;
          end else if (w16[RW_POS] == RW_READ) begin
            e_d.cmd_tog = ~e_q.cmd_tog;
            e_d.cmd_word = w16;
            f_d.ph = PH_READ;
          end else if (spfc_is_cmd(w16)) begin
            e_d.cmd_tog = ~e_q.cmd_tog;
            e_d.cmd_word = w16;
            f_d.ph = PH_DROP;
          end else begin
            f_d.ph = PH_WDATA;
          end
        end
      end
      // host crc of the command word
      PH_HCRC: begin
        if (f_q.cnt == HCRC_END) begin
          if (by != f_q.ccrc) begin
            e_d.err_tog = ~e_q.err_tog;
            f_d.ph = PH_DROP;
          end else if (f_q.cmd[RW_POS] == RW_READ) begin
            e_d.cmd_tog = ~e_q.cmd_tog;
            e_d.cmd_word = f_q.cmd;
            f_d.ph = PH_READ;
          end else if (spfc_is_cmd(f_q.cmd)) begin
            f_d.ph = PH_WAIT;
          end else begin
            f_d.ph = PH_WDATA;
          end
        end
      end
      // non-return command runs at the end of byte four
      PH_WAIT: begin
        if (f_q.cnt == CMD4_END) begin
          e_d.cmd_tog = ~e_q.cmd_tog;
          e_d.cmd_word = f_q.cmd;
          f_d.ph = PH_DROP;
        end
      end
      // write data bytes
      PH_WDATA: begin
        if (f_q.cnt[2:0] == 3'h7) begin
          if (!f_q.crc_s[1]) begin
            if (f_q.nby < (wide ? 2'h3 : 2'h2)) begin
              e_d.wr_tog = ~e_q.wr_tog;
              e_d.wr_idx = f_q.cmd[IDX_MSB:IDX_LSB];
              e_d.wr_mask = LANE_TOP >> lane;
              e_d.wr_data = {by, 16'h0000} >> {lane, 3'b000};
            end
            if (f_q.nby != 2'h3) begin
              f_d.nby = f_q.nby + 2'd1;
            end
          end else begin
            f_d.nby = f_q.nby + 2'd1;
            if (f_q.nby == (wide ? 2'h2 : 2'h1)) begin
              f_d.ph = PH_PCRC;
            end
          end
        end
      end
      // payload crc: commit whole word only on a match
      PH_PCRC: begin
        if (f_q.cnt[2:0] == 3'h7) begin
          pc = wide ? spfc_crc8({f_d.sh[31:8], 8'h00}, 6'd24)
                    : spfc_crc8({f_d.sh[23:8], 16'h0000}, 6'd16);
          f_d.pcrc = pc;
          f_d.ph = PH_RET;
          if (pc == by) begin
            e_d.wr_tog = ~e_q.wr_tog;
            e_d.wr_idx = f_q.cmd[IDX_MSB:IDX_LSB];
            e_d.wr_mask = wide ? 3'b111 : 3'b011;
            e_d.wr_data = wide ? f_d.sh[31:8] : {8'h00, f_d.sh[23:8]};
          end else begin
            e_d.err_tog = ~e_q.err_tog;
          end
        end
      end
      // device is talking or the frame is over
      PH_READ, PH_RET, PH_DROP: begin
        f_d.nby = f_q.nby;
      end
    endcase
  end

  // frame state lives only while chip select is low
  always_ff @(negedge sclk or posedge chip_select_low_n) begin
    if (chip_select_low_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  // event toggles survive frame ends, reset from the user side
  always_ff @(negedge sclk or posedge s_q.lrst) begin
    if (s_q.lrst) begin
      e_q <= '0;
    end else begin
      e_q <= e_d;
    end
  end

  // ----------------------------------------------------------------
  // link side: transmit path on rising edges
  // ----------------------------------------------------------------
  // load the word due in this slot, otherwise shift
  always_comb begin
    logic [39:0] lw;
    logic [7:0] ck;
    logic [5:0] n;
    logic [6:0] rd_at;
    lw = 40'h0;
    ck = 8'h00;
    n = 6'd16;
    rd_at = f_q.crc_s[1] ? RD_CRC : RD_NOCRC;
    if (spfc_is_cmd(f_q.cmd) && f_q.stat_s[1]) begin
      lw = {s_q.res, 8'h00};
      n = 6'd32;
    end else if (spfc_is_cmd(f_q.cmd)) begin
      lw = {s_q.res[23:0], 16'h0000};
      n = 6'd24;
    end else if (f_q.wide_s[1]) begin
      lw = {s_q.rdh, 16'h0000};
      n = 6'd24;
    end else begin
      lw = {s_q.rdh[15:0], 24'h000000};
    end
    ck = f_q.crc_s[1] ? spfc_crc8(lw[39:8], n) : 8'h00;
    lw = lw | ({ck, 32'h0} >> n);
    t_d.miso = t_q.tx[38];
    t_d.tx = {t_q.tx[37:0], 1'b0};
    if ((f_q.ph == PH_WAIT || f_q.ph == PH_READ) && f_q.crc_s[1]
        && f_q.cnt == CCRC_OUT) begin
      {t_d.miso, t_d.tx} = {f_q.ccrc, 32'h0};
    end else if (f_q.ph == PH_READ && f_q.cnt == rd_at) begin
      {t_d.miso, t_d.tx} = lw;
    end else if (f_q.ph == PH_RET && f_q.cnt == (f_q.wide_s[1] ? RET24 : RET16)) begin
      {t_d.miso, t_d.tx} = {f_q.pcrc, 32'h0};
    end
  end

  // output bit changes on the rising edge
  always_ff @(posedge sclk or posedge chip_select_low_n) begin
    if (chip_select_low_n) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  // ----------------------------------------------------------------
  // user side: crossings, registers, result buffer
  // ----------------------------------------------------------------
  // sync event toggles and apply them
  always_comb begin
    logic [23:0] m24;
    s_d = s_q;
    m24 = {{8{e_q.wr_mask[2]}}, {8{e_q.wr_mask[1]}}, {8{e_q.wr_mask[0]}}};
    s_d.lrst = 1'b0;
    s_d.wr_s = {s_q.wr_s[1:0], e_q.wr_tog};
    s_d.cmd_s = {s_q.cmd_s[1:0], e_q.cmd_tog};
    s_d.err_s = {s_q.err_s[1:0], e_q.err_tog};
    s_d.act_s = {s_q.act_s[0], ~chip_select_low_n};
    s_d.wr_p = s_q.wr_s[1] ^ s_q.wr_s[2];
    s_d.cmd_p = s_q.cmd_s[1] ^ s_q.cmd_s[2];
    // register write seen: publish it, update own config
    if (s_d.wr_p) begin
      s_d.wr_idx = e_q.wr_idx;
      s_d.wr_mask = e_q.wr_mask;
      s_d.wr_data = e_q.wr_data;
      if (e_q.wr_idx == CFG_IDX) begin
        s_d.cfg = (s_q.cfg & ~m24) | (e_q.wr_data & m24);
      end
    end
    // command seen: a status read clears the fault
    if (s_d.cmd_p) begin
      s_d.cmd_word = e_q.cmd_word;
      if (e_q.cmd_word[RW_POS] == RW_READ
          && e_q.cmd_word[IDX_MSB:IDX_LSB] == STAT_IDX) begin
        s_d.crc_err = 1'b0;
      end
    end
    // a new fault wins over a clear in the same cycle
    if (s_q.err_s[1] ^ s_q.err_s[2]) begin
      s_d.crc_err = 1'b1;
    end
    // read hold is frozen while a frame runs
    if (!s_q.act_s[1]) begin
      s_d.rdh = reg_rd_data;
    end
    // new result: buffer it, then pulse ready
    if (result_load) begin
      s_d.res = {result_status, result_data};
      s_d.rdy_cnt = RDY_CYCLES;
    end else if (s_q.rdy_cnt != 4'h0) begin
      s_d.rdy_cnt = s_q.rdy_cnt - 4'h1;
    end
    s_d.rdy = s_d.rdy_cnt != 4'h0;
  end

  // user side register, synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.cfg <= CFG_RST;
      s_q.lrst <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign miso = t_q.miso;
  assign miso_oe = ~chip_select_low_n;
  assign result_ready_pulse = s_q.rdy;
  assign reg_wr_pulse = s_q.wr_p;
  assign reg_wr_index = s_q.wr_idx;
  assign reg_wr_mask = s_q.wr_mask;
  assign reg_wr_data = s_q.wr_data;
  assign cmd_pulse = s_q.cmd_p;
  assign cmd_word = s_q.cmd_word;
  assign system_config_first = s_q.cfg;
  assign system_status_first = STAT_ERR_MASK & {24{s_q.crc_err}};
  assign checksum_fault = s_q.crc_err;
  assign general_pin_two = s_q.crc_err;
  assign general_pin_two_oe = s_q.cfg[CFG_ROUTE];
endmodule
`default_nettype wire

// ===== test/spfc_checker.sv
// checker for the serial target with crc-8: relations between its link and user-side ports
// assumes it is bound to spfc_spi_crc8 and sees only that module's ports
`default_nettype none
module spfc_checker
  import spfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_select_low_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic result_load,
  input wire logic result_ready_pulse,
  input wire logic reg_wr_pulse,
  input wire logic [2:0] reg_wr_mask,
  input wire logic cmd_pulse,
  input wire logic [23:0] system_config_first,
  input wire logic [23:0] system_status_first,
  input wire logic checksum_fault,
  input wire logic general_pin_two,
  input wire logic general_pin_two_oe
);
  // ------------------------------------------------------------
  // one user clock domain
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_oe_tracks_select: assert property (miso_oe == !chip_select_low_n)
    else $error("serial output enable differs from chip select");
  a_miso_idle_low: assert property (chip_select_low_n |-> miso == 1'b0)
    else $error("serial output not quiet outside a frame");
  a_ready_two_cycles: assert property (result_load |=> result_ready_pulse[*2] ##1 !result_ready_pulse)
    else $error("ready pulse length wrong");
  a_ready_has_cause: assert property ($rose(result_ready_pulse) |-> $past(result_load))
    else $error("ready without a loaded result");
  a_pin_routes_fault: assert property (general_pin_two == checksum_fault && general_pin_two_oe == system_config_first[CFG_ROUTE])
    else $error("pin two does not follow fault and route bit");
  a_status_mirror: assert property (system_status_first == {23'h000000, checksum_fault})
    else $error("status fault bit differs from fault flag");
  a_fault_clears_read: assert property ($fell(checksum_fault) |-> cmd_pulse || $past(cmd_pulse))
    else $error("fault cleared without a read");
  a_config_by_write: assert property ($changed(system_config_first) |-> reg_wr_pulse || $past(reg_wr_pulse))
    else $error("config changed without a write");
  a_write_has_lanes: assert property (reg_wr_pulse |-> (reg_wr_mask != 3'b000) ##1 !reg_wr_pulse)
    else $error("write pulse without lanes or too long");
  a_cmd_single: assert property (cmd_pulse |=> !cmd_pulse[*4])
    else $error("command executed more than once");
  // main scenarios
  c_full_write: cover property (reg_wr_pulse && reg_wr_mask == 3'b111);
  c_fault_set: cover property ($rose(checksum_fault));
  c_fault_clear: cover property ($fell(checksum_fault));
endmodule
bind spfc_spi_crc8 spfc_checker chk (.clk(clk), .rst_n(rst_n),
  .chip_select_low_n(chip_select_low_n), .miso(miso), .miso_oe(miso_oe),
  .result_load(result_load), .result_ready_pulse(result_ready_pulse),
  .reg_wr_pulse(reg_wr_pulse), .reg_wr_mask(reg_wr_mask), .cmd_pulse(cmd_pulse),
  .system_config_first(system_config_first), .system_status_first(system_status_first),
  .checksum_fault(checksum_fault), .general_pin_two(general_pin_two),
  .general_pin_two_oe(general_pin_two_oe));
`default_nettype wire

// ===== test/spfc_host_model.sv
// host serial controller model: frames, clocks and collects the target's output
// assumes the bench calls xfer; serial clock stands low outside frames
`default_nettype none
module spfc_host_model (
  output logic sclk,
  output logic chip_select_low_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // a chip select rise after time zero clears the target's frame and output state
  initial begin
    sclk = 1'b0;
    chip_select_low_n = 1'b0;
    mosi = 1'b0;
    #1;
    chip_select_low_n = 1'b1;
  end
  // clock the low n bits of tx msb first at 48 ns; hold keeps the frame open
  task automatic xfer(input logic [63:0] tx, input int n, input bit hold,
                      output logic [63:0] rx);
    rx = '0;
    if (chip_select_low_n) begin
      chip_select_low_n = 1'b0;
    end
    for (int i = n - 1; i >= 0; i--) begin
      #12 sclk = 1'b1;
      mosi = tx[i];
      #24 sclk = 1'b0;
      rx = {rx[62:0], miso};
      #12;
    end
    if (!hold) begin
      chip_select_low_n = 1'b1;
      mosi = ~mosi; // released line shows no stale value
    end
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the serial target with crc-8
// assumes the host model drives the link and the checker is bound to the target
`default_nettype none
module tb_top
  import spfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk, rst_n, reg_wide, device_select_pin, result_load;
  logic [23:0] reg_rd_data, result_data, wr_data, cfg, stat;
  logic [7:0] result_status;
  logic sclk, cs_n, mosi, miso, miso_oe, rdy, wr_p, cmd_p, fault, pin2, pin2_oe;
  logic [12:0] wr_idx;
  logic [2:0] wr_mask;
  logic [15:0] cmd_word;
  logic [63:0] rx;
  logic [39:0] wq[$];
  logic [15:0] cq[$];
  int errors, comparisons;
  spfc_spi_crc8 dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .chip_select_low_n(cs_n),
    .mosi(mosi), .device_select_pin(device_select_pin), .miso(miso), .miso_oe(miso_oe),
    .reg_wide(reg_wide), .reg_rd_data(reg_rd_data), .result_load(result_load),
    .result_data(result_data), .result_status(result_status), .result_ready_pulse(rdy),
    .reg_wr_pulse(wr_p), .reg_wr_index(wr_idx), .reg_wr_mask(wr_mask),
    .reg_wr_data(wr_data), .cmd_pulse(cmd_p), .cmd_word(cmd_word),
    .system_config_first(cfg), .system_status_first(stat), .checksum_fault(fault),
    .general_pin_two(pin2), .general_pin_two_oe(pin2_oe));
  spfc_host_model host (.sclk(sclk), .chip_select_low_n(cs_n), .mosi(mosi), .miso(miso));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // log every write and command event the target reports
  always @(negedge clk) begin
    if (wr_p) wq.push_back({wr_idx, wr_mask, wr_data});
    if (cmd_p) cq.push_back(cmd_word);
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // crc-8 over the low n bits, msb first, zero start, no inversion
  function automatic logic [7:0] crc(input logic [31:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // command word with select bit matching the strap
  function automatic logic [15:0] w(input logic rw, input logic [12:0] idx);
    return {1'b1, rw, idx, 1'b0};
  endfunction
  task automatic frame(input logic [63:0] tx, input int n, input bit hold);
    wq.delete();
    cq.delete();
    repeat (2) @(negedge clk);
    host.xfer(tx, n, hold, rx);
    if (!hold) repeat (10) @(negedge clk);
  endtask
  task automatic rd_status;
    logic [15:0] sw;
    sw = w(1'b1, STAT_IDX);
    reg_rd_data = 24'h000001;
    frame({sw, crc(sw, 16), 8'h00, 32'h0}, 64, 0);
    check(64'(rx[31:0]), 64'({24'h000001, crc(32'h1, 24)}));
    check(64'(fault), 64'h0);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_plain;
    check(64'({cfg, stat, fault, rdy, miso_oe, miso}), 64'h0);
    reg_rd_data = 24'h5a3c96;
    frame({w(1'b1, 13'h0040), 24'h0}, 40, 0);
    check(64'(rx[23:0]), 64'h5a3c96);
    frame({1'b0, 1'b0, CFG_IDX, 1'b0, 8'hff}, 24, 0);
    check(64'(wq.size()), 64'h0);
    frame({w(1'b0, CFG_IDX), 8'ha5}, 24, 0);
    check(64'(wq[0][39:16]), 64'({CFG_IDX, 3'b100, 8'ha5}));
    check(64'(cfg), 64'ha50000);
    frame({w(1'b0, CFG_IDX), 24'h000480}, 40, 0);
    for (int i = 0; i < 3; i++) check(64'(wq[i][26:24]), 64'(3'b100 >> i));
    check(64'(cfg), 64'h000480);
    $display("plain transfers ended");
  endtask
  task automatic t_crc_cmd;
    logic [15:0] cw;
    cw = w(1'b0, 13'h0003);
    frame({cw, crc(cw, 16), 8'h00}, 32, 0);
    check(64'(rx[7:0]), 64'(crc(cw, 16)));
    check(64'({cq.size(), cq[0]}), 64'({32'd1, cw}));
    frame({cw, crc(cw, 16) ^ 8'h01, 8'h00}, 32, 0);
    check(64'(cq.size()), 64'h0);
    check(64'({stat, fault, pin2, pin2_oe}), 64'({24'h000001, 3'b111}));
    rd_status;
    frame({cw, crc(cw, 16)}, 24, 0);
    check(64'(cq.size()), 64'h0);
    $display("crc command ended");
  endtask
  task automatic t_crc_write;
    logic [15:0] ww;
    ww = w(1'b0, CFG_IDX);
    frame({ww, crc(ww, 16), 24'h000680, crc(32'h680, 24), 8'h00}, 64, 0);
    check(64'(rx[7:0]), 64'(crc(32'h680, 24)));
    check(64'({wq.size(), wq[0][26:0]}), 64'({32'd1, 3'b111, 24'h000680}));
    frame({ww, crc(ww, 16), 24'h000080, crc(32'h80, 24) ^ 8'h01, 8'h00}, 64, 0);
    check(64'({wq.size(), cfg, fault}), 64'({32'd0, 24'h000680, 1'b1}));
    rd_status;
    $display("crc write ended");
  endtask
  task automatic t_result;
    logic [15:0] rw;
    logic [15:0] ww;
    logic [39:0] want;
    rw = w(1'b1, 13'h0001);
    ww = w(1'b0, CFG_IDX);
    // first pass with the status prefix on, second with it turned off
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        frame({ww, crc(ww, 16), 24'h000480, crc(32'h480, 24), 8'h00}, 64, 0);
        check(64'(cfg), 64'h000480);
      end
      frame({rw, crc(rw, 16), 8'h00}, 32, 1);
      check(64'(miso_oe), 64'h1);
      @(negedge clk);
      result_data = 24'h123456;
      result_status = 8'h81;
      result_load = 1'b1;
      @(negedge clk);
      result_load = 1'b0;
      for (int i = 0; i < 8 && rdy !== 1'b1; i++) @(negedge clk);
      check(64'(rdy), 64'h1);
      frame(64'h0, 40, 0);
      if (p == 0) begin
        want = {32'h81123456, crc(32'h81123456, 32)};
      end else begin
        want = {24'h123456, crc(32'h123456, 24), 8'h00};
      end
      check(64'(rx[39:0]), 64'(want));
    end
    $display("result read ended");
  endtask
  initial begin
    rst_n = 1'b0;
    reg_wide = 1'b1;
    device_select_pin = 1'b1;
    result_load = 1'b0;
    reg_rd_data = 24'h0;
    result_data = 24'h0;
    result_status = 8'h00;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_plain;
    t_crc_cmd;
    t_crc_write;
    t_result;
    print_verdict;
  end
  // watchdog well beyond the expected run of some 38 us
  initial begin
    #300us;
    errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
